// file: core/expander_device.sv
// Expander end: terminates module support pins behind the serial link.
//
// Function
// RQ1: Module pins reachable only via four-wire link.
// RQ2: Host runs link clock freely, at most 1MHz.
// RQ3: Transaction starts with select and direction low.
// RQ4: Five command bits shifted in, one per clock.
// RQ5: Decode the four read command codes.
// RQ6: Decode the four write command codes.
// RQ7: Read command: host keeps direction low afterwards.
// RQ8: Write command: host raises direction after command.
// RQ9: Read: expander drives four status bits.
// RQ10: Fixed order of the four read bits.
// RQ11: Fixed order of the host's write bits.
// RQ12: Two red indicators per SFP channel.
// RQ13: Host deselects XFP modules through write path.
// RQ14: Select returns high after data, one-clock gap.
// RQ15: Launch on falling edge, sample on rising.
//
// The placing of the registers and the address-and-strobe port were decided locally.
module expander_device (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rstn,
	// Serial link.
	expander_link_if.dev link,
	// SFP module inputs.
	input wire logic [1:0] sfp_laser_fault,
	input wire logic [1:0] receive_signal_missing,
	input wire logic [1:0] sfp_def_line0,
	input wire logic [1:0] sfp_def_line2_in,
	// SFP module outputs.
	output logic [1:0] sfp_def_line1,
	output logic [1:0] sfp_def_line2_out,
	output logic [1:0] sfp_def_line2_drive,
	output logic [1:0] speed_select,
	output logic [1:0] sfp_transmitter_off,
	// XFP module inputs.
	input wire logic [1:0] module_irq_low,
	input wire logic [1:0] module_absent,
	input wire logic [1:0] module_not_ready,
	input wire logic [1:0] xfp_rx_loss,
	// XFP module outputs.
	output logic [1:0] xfp_deselect_line,
	output logic [1:0] xfp_transmitter_off,
	output logic [1:0] module_sleep,
	// Indicators.
	output logic [1:0] rx_loss_led,
	output logic [1:0] laser_fault_led
);
	import expander_pkg::*;

	logic lk_clk;
	logic lk_sel_n;
	logic lk_dir;
	logic lk_data;
	logic [15:0] pins_s;
	logic [1:0] s_def2;
	logic [1:0] s_def0;
	logic [1:0] s_los;
	logic [1:0] s_fault;
	logic [1:0] x_rxloss;
	logic [1:0] x_nr;
	logic [1:0] x_abs;
	logic [1:0] x_irq_n;
	logic sclk_d_ff;
	logic rise;
	logic fall;
	dev_state_e state_ff;
	logic [2:0] cnt_ff;
	logic [4:0] cmd_ff;
	logic [4:0] nxt_cmd;
	cmd_decode_s dec_ff;
	cmd_decode_s nxt_dec;
	logic [3:0] snap_ff;
	logic [3:0] nxt_status;
	logic [4:0] wshift_ff;
	logic [4:0] nxt_wbits;
	logic last_wbit;
	logic write_done;
	logic data_out_ff;
	logic data_oe_ff;

	// Every link wire and module pin is asynchronous to clk_sys.
	sync_2ff #(
		.WIDTH(4),
		.RESET_VAL(LINK_SYNC_RESET)
	) u_link_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.d({link.expander_clk, link.select_n, link.expander_direction,
			link.expander_data}),
		.q({lk_clk, lk_sel_n, lk_dir, lk_data})
	);

	sync_2ff #(
		.WIDTH(16),
		.RESET_VAL(PIN_SYNC_RESET)
	) u_pin_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.d({sfp_def_line2_in, sfp_def_line0, receive_signal_missing,
			sfp_laser_fault, xfp_rx_loss, module_not_ready, module_absent,
			module_irq_low}),
		.q(pins_s)
	);

	assign {s_def2, s_def0, s_los, s_fault, x_rxloss, x_nr, x_abs,
		x_irq_n} = pins_s;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sclk_d_ff <= 1'b0;
		end else begin
			sclk_d_ff <= lk_clk;
		end
	end

	assign rise = lk_clk & ~sclk_d_ff; // RQ15
	assign fall = ~lk_clk & sclk_d_ff; // RQ15

	assign nxt_cmd = {cmd_ff[3:0], lk_data}; // RQ4
	assign nxt_dec = decode_cmd(nxt_cmd); // RQ5 RQ6

	// Status is frozen at the end of the command so all four bits belong
	// to one instant, even if a pin moves during the data phase.
	always_comb begin
		if (nxt_dec.is_xfp) begin
			nxt_status = {x_rxloss[nxt_dec.unit], x_nr[nxt_dec.unit],
				x_abs[nxt_dec.unit], x_irq_n[nxt_dec.unit]}; // RQ10
		end else begin
			nxt_status = {s_def2[nxt_dec.unit], s_def0[nxt_dec.unit],
				s_los[nxt_dec.unit], s_fault[nxt_dec.unit]}; // RQ10
		end
	end

	always_comb begin
		nxt_wbits = wshift_ff;
		nxt_wbits[cnt_ff] = lk_data;
	end

	assign last_wbit = (cnt_ff == data_bits(dec_ff) - 3'h1);
	assign write_done = rise & ~lk_sel_n & lk_dir & last_wbit &
		(state_ff == DEV_WRITE);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_ff <= DEV_IDLE;
			cnt_ff <= 3'h0;
			cmd_ff <= 5'h00;
			dec_ff <= '0;
			snap_ff <= 4'h0;
			wshift_ff <= 5'h00;
		end else if (lk_sel_n) begin
			state_ff <= DEV_IDLE;
			cnt_ff <= 3'h0;
		end else if (rise) begin
			case (state_ff)
				DEV_IDLE: begin
					// A frame opened with direction high is not a command.
					if (!lk_dir) begin // RQ3
						cmd_ff <= nxt_cmd;
						cnt_ff <= 3'h1;
						state_ff <= DEV_CMD;
					end else begin
						state_ff <= DEV_HOLD;
					end
				end
				DEV_CMD: begin
					cmd_ff <= nxt_cmd; // RQ4
					if (cnt_ff == 3'(CMD_BITS - 1)) begin
						cnt_ff <= 3'h0;
						dec_ff <= nxt_dec;
						snap_ff <= nxt_status;
						if (!nxt_dec.valid) begin
							state_ff <= DEV_HOLD;
						end else if (nxt_dec.is_read) begin
							state_ff <= DEV_READ; // RQ5
						end else begin
							state_ff <= DEV_WRITE; // RQ6
						end
					end else begin
						cnt_ff <= cnt_ff + 3'h1;
					end
				end
				DEV_READ: begin
					// A host that raises direction in a read gets no more data.
					if (lk_dir || cnt_ff == 3'(RD_BITS - 1)) begin // RQ9
						state_ff <= DEV_HOLD;
					end else begin
						cnt_ff <= cnt_ff + 3'h1;
					end
				end
				DEV_WRITE: begin
					if (!lk_dir) begin
						state_ff <= DEV_HOLD;
					end else begin
						wshift_ff <= nxt_wbits;
						if (last_wbit) begin
							state_ff <= DEV_HOLD;
						end else begin
							cnt_ff <= cnt_ff + 3'h1;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Read bits launch on the falling edge so they are settled at the
	// host's rising-edge sample; the line is released after the last one.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			data_out_ff <= 1'b0;
			data_oe_ff <= 1'b0;
		end else if (lk_sel_n) begin
			data_oe_ff <= 1'b0;
		end else if (fall) begin
			if (state_ff == DEV_READ) begin
				data_out_ff <= snap_ff[cnt_ff[1:0]]; // RQ9 RQ10 RQ15
				data_oe_ff <= 1'b1;
			end else begin
				data_oe_ff <= 1'b0;
			end
		end
	end

	assign link.dev_data_out = data_out_ff;
	assign link.dev_data_oe = data_oe_ff;

	// Outputs change only when a whole write frame has arrived, so a
	// truncated frame never leaves a module half updated.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sfp_def_line1 <= SFP_OUT_RESET;
			sfp_def_line2_out <= SFP_OUT_RESET;
			sfp_def_line2_drive <= SFP_OUT_RESET;
			speed_select <= SFP_OUT_RESET;
			sfp_transmitter_off <= SFP_TXOFF_RESET;
			xfp_deselect_line <= XFP_DESEL_RESET;
			xfp_transmitter_off <= XFP_TXOFF_RESET;
			module_sleep <= XFP_SLEEP_RESET;
		end else if (write_done) begin
			if (dec_ff.is_xfp) begin
				xfp_deselect_line[dec_ff.unit] <= nxt_wbits[0]; // RQ1 RQ13
				xfp_transmitter_off[dec_ff.unit] <= nxt_wbits[1];
				module_sleep[dec_ff.unit] <= nxt_wbits[2];
			end else begin
				sfp_def_line1[dec_ff.unit] <= nxt_wbits[0]; // RQ1
				sfp_def_line2_out[dec_ff.unit] <= nxt_wbits[1];
				sfp_def_line2_drive[dec_ff.unit] <= nxt_wbits[2];
				speed_select[dec_ff.unit] <= nxt_wbits[3];
				sfp_transmitter_off[dec_ff.unit] <= nxt_wbits[4];
			end
		end
	end

	// A module that is not seated reports a high presence line.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rx_loss_led <= 2'h0;
			laser_fault_led <= 2'h0;
		end else begin
			rx_loss_led <= s_los; // RQ12
			laser_fault_led <= s_fault | s_def0; // RQ12
		end
	end

endmodule : expander_device

// file: core/expander_pkg.sv
// Shared constants, types and decode helpers for the expander serial link.
package expander_pkg;

	// Link framing.
	localparam int CMD_BITS = 5;
	localparam int RD_BITS = 4;
	localparam int WR_BITS_SFP = 5;
	localparam int WR_BITS_XFP = 4;

	// Command codes.
	localparam logic [4:0] CMD_READ_SFP_A = 5'h13;
	localparam logic [4:0] CMD_READ_SFP_B = 5'h14;
	localparam logic [4:0] CMD_READ_XFP_A = 5'h15;
	localparam logic [4:0] CMD_READ_XFP_B = 5'h16;
	localparam logic [4:0] CMD_WRITE_SFP_A = 5'h07;
	localparam logic [4:0] CMD_WRITE_SFP_B = 5'h08;
	localparam logic [4:0] CMD_WRITE_XFP_A = 5'h09;
	localparam logic [4:0] CMD_WRITE_XFP_B = 5'h0a;

	// Timing: the link clock may not run faster than 1 MHz.
	localparam int SYS_PERIOD_NS = 8;
	localparam int LINK_MIN_PERIOD_NS = 1000;
	localparam int LINK_HALF_CYCLES =
		(LINK_MIN_PERIOD_NS / 2 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

	// Host register map and fields.
	localparam int REG_ADDR_W = 8;
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_WDATA = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_BAD = 2;
	localparam int STAT_RDATA_LSB = 8;

	// Reset values.
	localparam logic [3:0] LINK_SYNC_RESET = 4'h5;
	localparam logic [15:0] PIN_SYNC_RESET = 16'h0003;
	localparam logic [1:0] SFP_OUT_RESET = 2'h0;
	localparam logic [1:0] SFP_TXOFF_RESET = 2'h3;
	localparam logic [1:0] XFP_DESEL_RESET = 2'h3;
	localparam logic [1:0] XFP_TXOFF_RESET = 2'h3;
	localparam logic [1:0] XFP_SLEEP_RESET = 2'h0;

	typedef enum {LINK_IDLE, LINK_CMD, LINK_DATA, LINK_GAP} link_state_e;
	typedef enum {DEV_IDLE, DEV_CMD, DEV_READ, DEV_WRITE, DEV_HOLD}
		dev_state_e;

	typedef struct packed {
		logic valid;
		logic is_read;
		logic is_xfp;
		logic unit;
	} cmd_decode_s;

	function automatic cmd_decode_s decode_cmd(input logic [4:0] cmd);
		cmd_decode_s d;
		d = '0;
		d.valid = 1'b1;
		case (cmd)
			CMD_READ_SFP_A: d.is_read = 1'b1;
			CMD_READ_SFP_B: begin
				d.is_read = 1'b1;
				d.unit = 1'b1;
			end
			CMD_READ_XFP_A: begin
				d.is_read = 1'b1;
				d.is_xfp = 1'b1;
			end
			CMD_READ_XFP_B: begin
				d.is_read = 1'b1;
				d.is_xfp = 1'b1;
				d.unit = 1'b1;
			end
			CMD_WRITE_SFP_A: d.unit = 1'b0;
			CMD_WRITE_SFP_B: d.unit = 1'b1;
			CMD_WRITE_XFP_A: d.is_xfp = 1'b1;
			CMD_WRITE_XFP_B: begin
				d.is_xfp = 1'b1;
				d.unit = 1'b1;
			end
			default: d.valid = 1'b0;
		endcase
		return d;
	endfunction : decode_cmd

	function automatic logic [2:0] data_bits(input cmd_decode_s d);
		if (d.is_read) begin
			return 3'(RD_BITS);
		end else if (d.is_xfp) begin
			return 3'(WR_BITS_XFP);
		end
		return 3'(WR_BITS_SFP);
	endfunction : data_bits

endpackage : expander_pkg

// file: core/expander_link_if.sv
// Four-wire serial link between the host logic and the expander.
interface expander_link_if;
	logic expander_clk;
	logic select_n;
	logic expander_direction;
	logic host_data_out;
	logic host_data_oe;
	logic dev_data_out;
	logic dev_data_oe;
	logic expander_data;

	// An undriven data line floats high through its pull-up.
	assign expander_data = host_data_oe ? host_data_out :
		(dev_data_oe ? dev_data_out : 1'b1);

	modport host (
		output expander_clk,
		output select_n,
		output expander_direction,
		output host_data_out,
		output host_data_oe,
		input expander_data
	);

	modport dev (
		input expander_clk,
		input select_n,
		input expander_direction,
		input expander_data,
		output dev_data_out,
		output dev_data_oe
	);
endinterface : expander_link_if

// file: core/sync_2ff.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
module sync_2ff #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rstn,
	// Data.
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			meta_ff <= RESET_VAL;
			q <= RESET_VAL;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule : sync_2ff

// file: core/expander_host.sv
// Host end: register-driven controller that runs the expander link.
module expander_host #(
	parameter int LINK_HALF = expander_pkg::LINK_HALF_CYCLES
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rstn,
	// Register port.
	input wire logic [expander_pkg::REG_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Serial link.
	expander_link_if.host link
);
	import expander_pkg::*;

	localparam int DIV_W = $clog2(LINK_HALF + 1);

	logic [DIV_W-1:0] div_ff;
	logic sclk_ff;
	logic wrap;
	logic rise_evt;
	logic fall_evt;
	logic data_s;
	link_state_e state_ff;
	logic [2:0] cnt_ff;
	logic [4:0] cmd_ff;
	logic [4:0] wdata_ff;
	logic go_ff;
	logic done_ff;
	logic bad_ff;
	logic [3:0] rshift_ff;
	logic [3:0] rdata_ff;
	logic sel_n_ff;
	logic dir_ff;
	logic out_ff;
	logic oe_ff;
	logic busy;
	logic [2:0] nbits;
	logic xfer_end;
	logic cmd_wr;
	cmd_decode_s wdec;
	cmd_decode_s cdec;

	sync_2ff #(
		.WIDTH(1),
		.RESET_VAL(1'b1)
	) u_data_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.d(link.expander_data),
		.q(data_s)
	);

	// The link clock runs free even between frames.
	assign wrap = (div_ff == DIV_W'(LINK_HALF - 1));
	assign rise_evt = wrap & ~sclk_ff; // RQ2
	assign fall_evt = wrap & sclk_ff; // RQ15

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			div_ff <= '0;
			sclk_ff <= 1'b0;
		end else if (wrap) begin
			div_ff <= '0;
			sclk_ff <= ~sclk_ff; // RQ2
		end else begin
			div_ff <= div_ff + 1'b1;
		end
	end

	assign busy = go_ff | (state_ff != LINK_IDLE);
	assign cdec = decode_cmd(cmd_ff);
	assign wdec = decode_cmd(reg_wdata[4:0]);
	assign nbits = data_bits(cdec);
	assign xfer_end = fall_evt & (state_ff == LINK_DATA) & (cnt_ff == nbits);
	assign cmd_wr = reg_wr & (reg_addr == REG_CMD) & ~busy;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cmd_ff <= 5'h00;
			wdata_ff <= 5'h00;
		end else begin
			if (cmd_wr && wdec.valid) begin
				cmd_ff <= reg_wdata[4:0];
			end
			if (reg_wr && reg_addr == REG_WDATA && !busy) begin
				wdata_ff <= reg_wdata[4:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			go_ff <= 1'b0;
		end else if (cmd_wr && wdec.valid) begin
			go_ff <= 1'b1;
		end else if (fall_evt && state_ff == LINK_IDLE) begin
			go_ff <= 1'b0;
		end
	end

	// Sticky flags clear on a status read; a new event in that cycle wins.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			done_ff <= 1'b0;
			bad_ff <= 1'b0;
			rdata_ff <= 4'h0;
		end else begin
			if (xfer_end) begin
				done_ff <= 1'b1;
				rdata_ff <= cdec.is_read ? rshift_ff : rdata_ff;
			end else if (reg_rd && reg_addr == REG_STATUS) begin
				done_ff <= 1'b0;
			end
			if (cmd_wr && !wdec.valid) begin
				bad_ff <= 1'b1;
			end else if (reg_rd && reg_addr == REG_STATUS) begin
				bad_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_ff <= LINK_IDLE;
			cnt_ff <= 3'h0;
			rshift_ff <= 4'h0;
			sel_n_ff <= 1'b1;
			dir_ff <= 1'b0;
			out_ff <= 1'b1;
			oe_ff <= 1'b0;
		end else if (rise_evt) begin
			if (state_ff == LINK_CMD) begin
				cnt_ff <= cnt_ff + 3'h1;
			end else if (state_ff == LINK_DATA) begin
				if (cdec.is_read) begin
					rshift_ff[cnt_ff[1:0]] <= data_s; // RQ9
				end
				cnt_ff <= cnt_ff + 3'h1;
			end
		end else if (fall_evt) begin
			case (state_ff)
				LINK_IDLE: begin
					if (go_ff) begin
						sel_n_ff <= 1'b0; // RQ3
						dir_ff <= 1'b0; // RQ3
						out_ff <= cmd_ff[4]; // RQ4
						oe_ff <= 1'b1;
						cnt_ff <= 3'h0;
						state_ff <= LINK_CMD;
					end
				end
				LINK_CMD: begin
					if (cnt_ff == 3'(CMD_BITS)) begin
						cnt_ff <= 3'h0;
						state_ff <= LINK_DATA;
						if (cdec.is_read) begin
							oe_ff <= 1'b0; // RQ7 RQ15
						end else begin
							dir_ff <= 1'b1; // RQ8
							out_ff <= wdata_ff[0]; // RQ11
						end
					end else begin
						out_ff <= cmd_ff[3'(CMD_BITS - 1) - cnt_ff]; // RQ4
					end
				end
				LINK_DATA: begin
					if (cnt_ff == nbits) begin
						sel_n_ff <= 1'b1; // RQ14
						dir_ff <= 1'b0;
						oe_ff <= 1'b0;
						state_ff <= LINK_GAP;
					end else if (!cdec.is_read) begin
						out_ff <= wdata_ff[cnt_ff]; // RQ11 RQ13
					end
				end
				default: state_ff <= LINK_IDLE; // RQ14
			endcase
		end
	end

	assign link.expander_clk = sclk_ff;
	assign link.select_n = sel_n_ff;
	assign link.expander_direction = dir_ff;
	assign link.host_data_out = out_ff;
	assign link.host_data_oe = oe_ff;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			if (reg_addr == REG_CMD) begin
				reg_rdata <= {27'h0, cmd_ff};
			end else if (reg_addr == REG_WDATA) begin
				reg_rdata <= {27'h0, wdata_ff};
			end else if (reg_addr == REG_STATUS) begin
				reg_rdata <= {20'h0, rdata_ff, 5'h0, bad_ff, done_ff, busy};
			end else begin
				reg_rdata <= 32'h0;
			end
		end else begin
			reg_rdata <= 32'h0;
		end
	end

endmodule : expander_host

// file: dv/expander_link_asserts.sv
// Protocol assertions on the serial link between host and expander.
module expander_link_asserts #(
	parameter int LINK_HALF = expander_pkg::LINK_HALF_CYCLES
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rstn,
	// Link signals.
	input wire logic expander_clk,
	input wire logic select_n,
	input wire logic expander_direction,
	input wire logic host_data_oe,
	input wire logic dev_data_oe,
	input wire logic expander_data
);
	import expander_pkg::*;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	logic clk_q_ff;
	logic seen_ff;
	logic [7:0] half_ff;
	logic [7:0] gap_ff;
	logic [3:0] rises_ff;
	logic [4:0] cmd_ff;
	logic tgl;
	logic rise;
	logic is_xw;

	assign tgl = expander_clk != clk_q_ff;
	assign rise = expander_clk && !clk_q_ff;
	assign is_xw = cmd_ff == CMD_WRITE_XFP_A || cmd_ff == CMD_WRITE_XFP_B;

	// The first toggle after reset has no known start, so it is not timed.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			clk_q_ff <= 1'b0;
			seen_ff <= 1'b0;
			half_ff <= 8'h00;
		end else if (tgl) begin
			clk_q_ff <= expander_clk;
			seen_ff <= 1'b1;
			half_ff <= 8'h00;
		end else begin
			half_ff <= half_ff + 8'h01;
		end
	end

	// Starts saturated so the first frame after reset is not judged short.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			gap_ff <= 8'hff;
		end else if (!select_n) begin
			gap_ff <= 8'h00;
		end else if (gap_ff != 8'hff) begin
			gap_ff <= gap_ff + 8'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rises_ff <= 4'h0;
			cmd_ff <= 5'h00;
		end else if (select_n) begin
			rises_ff <= 4'h0;
		end else if (rise) begin
			rises_ff <= rises_ff + 4'h1;
			if (rises_ff < 4'h5) begin
				cmd_ff <= {cmd_ff[3:0], expander_data};
			end
		end
	end

	sequence fall5_s;
		!select_n && rises_ff == 4'h5 && $fell(expander_clk);
	endsequence

	sequence dev_takes_s;
		!host_data_oe ##[1:8] dev_data_oe;
	endsequence

	AST_HALF:
	assert property (tgl && seen_ff |-> half_ff == LINK_HALF - 1)
		else $error("Link clock half period is wrong.");
	AST_START:
	assert property ($fell(select_n) |-> !expander_direction && host_data_oe)
		else $error("Frame did not start with direction low.");
	AST_SEL_EDGE:
	assert property ($changed(select_n) || $changed(expander_direction)
		|-> $fell(expander_clk)) else $error("Control moved off a fall.");
	AST_DATA_EDGE:
	assert property ($changed(expander_data) && host_data_oe
		&& $past(host_data_oe) |-> $fell(expander_clk))
		else $error("Host data moved off a fall.");
	AST_READ_DIR:
	assert property (!select_n && rises_ff >= 4'h5 && cmd_ff[4]
		|-> !expander_direction) else $error("Direction rose in a read.");
	AST_WRITE_DIR:
	assert property (fall5_s ##0 !cmd_ff[4] |-> expander_direction)
		else $error("Direction not raised for a write.");
	AST_READ_TURN:
	assert property (fall5_s ##0 cmd_ff[4] |-> dev_takes_s)
		else $error("Expander did not take the line for a read.");
	AST_COUNT:
	assert property ($rose(select_n)
		|-> rises_ff == ((cmd_ff[4] || is_xw) ? 4'h9 : 4'ha))
		else $error("Wrong clock count in a frame.");
	AST_RELEASE:
	assert property ($rose(select_n) |-> !host_data_oe ##[0:8] !dev_data_oe)
		else $error("Data line not released after a frame.");
	AST_NO_FIGHT:
	assert property (!(host_data_oe && dev_data_oe))
		else $error("Both ends drive the data line.");
	AST_GAP:
	assert property ($fell(select_n) |-> gap_ff >= 2 * LINK_HALF)
		else $error("Select gap between frames too short.");
endmodule : expander_link_asserts

// file: dv/tb_top.sv
// Bench joining host and expander over the link, driven by registers.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import expander_pkg::*;

	localparam int HALF = 10;
	localparam logic [4:0] RC [4] = '{CMD_READ_SFP_A, CMD_READ_SFP_B,
		CMD_READ_XFP_A, CMD_READ_XFP_B};
	localparam logic [4:0] WC [4] = '{CMD_WRITE_SFP_A, CMD_WRITE_SFP_B,
		CMD_WRITE_XFP_A, CMD_WRITE_XFP_B};

	logic clk_sys;
	logic rstn;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic [15:0] pins;
	logic [1:0] def1, def2, drv, spd, stx, xds, xtx, slp, rxl, lfl;
	logic [1:0] m [8];
	logic [15:0] outs;
	logic [15:0] want;
	logic [31:0] s;
	logic done_seen;
	int err_count;
	int checks_done;

	assign outs = {def1, def2, drv, spd, stx, xds, xtx, slp};
	assign want = {m[0], m[1], m[2], m[3], m[4], m[5], m[6], m[7]};

	expander_link_if link();

	expander_host #(.LINK_HALF(HALF)) expander_host_inst (.clk_sys(clk_sys),
		.rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link));

	expander_device expander_device_inst (.clk_sys(clk_sys), .rstn(rstn),
		.link(link), .sfp_laser_fault(pins[1:0]),
		.receive_signal_missing(pins[3:2]), .sfp_def_line0(pins[5:4]),
		.sfp_def_line2_in(pins[7:6]), .module_irq_low(pins[9:8]),
		.module_absent(pins[11:10]), .module_not_ready(pins[13:12]),
		.xfp_rx_loss(pins[15:14]), .sfp_def_line1(def1),
		.sfp_def_line2_out(def2), .sfp_def_line2_drive(drv),
		.speed_select(spd), .sfp_transmitter_off(stx),
		.xfp_deselect_line(xds), .xfp_transmitter_off(xtx),
		.module_sleep(slp), .rx_loss_led(rxl), .laser_fault_led(lfl));

	expander_link_asserts #(.LINK_HALF(HALF)) expander_link_asserts_inst (
		.clk_sys(clk_sys), .rstn(rstn), .expander_clk(link.expander_clk),
		.select_n(link.select_n),
		.expander_direction(link.expander_direction),
		.host_data_oe(link.host_data_oe), .dev_data_oe(link.dev_data_oe),
		.expander_data(link.expander_data));

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask : rd

	// A status read clears done, and done rises before busy falls, so the
	// flag is gathered over every poll rather than taken from the last one.
	task automatic wait_idle();
		done_seen = 1'b0;
		for (int n = 0; n < 400; n++) begin
			rd(REG_STATUS, s);
			done_seen = done_seen | s[STAT_DONE];
			if (s[STAT_BUSY] === 1'b0)
				return;
		end
		err_count++;
		$display("BAD %0t link stuck busy", $time);
	endtask : wait_idle

	task automatic run(input logic [4:0] c, input logic [4:0] d);
		wr(REG_WDATA, {27'h0, d});
		wr(REG_CMD, {27'h0, c});
		wait_idle();
	endtask : run

	task automatic t_reset();
		chk(outs, want);
		chk(link.select_n, 1'b1);
		rd(8'h0c, s);
		chk(s, 32'h0);
	endtask : t_reset

	task automatic t_read();
		logic [3:0] e;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_sys);
			pins <= k ? 16'h5a3c : 16'ha5c3;
			repeat (4) @(posedge clk_sys);
			chk(rxl, pins[3:2]);
			chk(lfl, pins[1:0] | pins[5:4]);
			for (int i = 0; i < 4; i++) begin
				for (int j = 0; j < 4; j++)
					e[j] = pins[8 * i[1] + 2 * j + i[0]];
				run(RC[i], 5'h00);
				chk(s[STAT_RDATA_LSB +: 4], e);
				chk(done_seen, 1'b1);
			end
		end
	endtask : t_read

	task automatic t_write();
		logic [4:0] d;
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 4; i++) begin
				d = k ? 5'h0a : 5'h15;
				for (int j = 0; j < 5; j++)
					if (i[1] == 1'b0 || j < 3)
						m[j + 5 * i[1]][i[0]] = d[j];
				run(WC[i], d);
				repeat (4) @(posedge clk_sys);
				chk(outs, want);
				chk(done_seen, 1'b1);
				rd(REG_WDATA, s);
				chk(s, {27'h0, d});
				rd(REG_CMD, s);
				chk(s, {27'h0, WC[i]});
			end
		end
	endtask : t_write

	// A bad code and orders given while busy must leave the pins alone.
	task automatic t_refuse();
		wr(REG_CMD, 32'h1f);
		rd(REG_STATUS, s);
		chk(s[STAT_BAD], 1'b1);
		chk(link.select_n, 1'b1);
		rd(REG_STATUS, s);
		chk(s[STAT_BAD], 1'b0);
		wr(REG_CMD, {27'h0, CMD_READ_SFP_A});
		wr(REG_WDATA, 32'h1f);
		wr(REG_CMD, {27'h0, CMD_WRITE_SFP_B});
		wait_idle();
		repeat (6 * HALF) @(posedge clk_sys);
		rd(REG_STATUS, s);
		chk(s[STAT_BUSY], 1'b0);
		chk(outs, want);
		rd(REG_WDATA, s);
		chk(s, 32'h0000000a);
		rd(REG_CMD, s);
		chk(s, {27'h0, CMD_READ_SFP_A});
	endtask : t_refuse

	task automatic print_verdict();
		if (err_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (40000) @(posedge clk_sys);
		err_count++;
		print_verdict();
	end

	initial begin
		rstn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		pins = 16'h0000;
		err_count = 0;
		checks_done = 0;
		m = '{SFP_OUT_RESET, SFP_OUT_RESET, SFP_OUT_RESET, SFP_OUT_RESET,
			SFP_TXOFF_RESET, XFP_DESEL_RESET, XFP_TXOFF_RESET, XFP_SLEEP_RESET};
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset();
		t_read();
		t_write();
		t_refuse();
		print_verdict();
	end
endmodule : tb_top
